// [reset_strap_sampler.sv]
/*
 * Strap sampler: releases the configuration pins during power-on reset,
 * captures them after the settling delay, holds the result, and lets
 * software drive the pins as debug outputs afterwards. AXI4-Lite slave.
 * Assumes all inputs are synchronous to aclk and pads resolve the wire
 * from the out/oe pairs, applying the weak pull-down when requested.
 */
`timescale 1ns/10ps
module reset_strap_sampler #(
    parameter int ADDR_W       = 8,
    parameter int DELAY_CYCLES = strap_pkg::CAPTURE_CYCLES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Power-on input and strap pads
    input  wire logic              por_n_input,
    input  wire logic              integrity_select_strap_in,
    output logic                   integrity_select_strap_out,
    output logic                   integrity_select_strap_oe,
    input  wire logic              boot_hold_strap_in,
    output logic                   boot_hold_strap_out,
    output logic                   boot_hold_strap_oe,
    input  wire logic              test_strap_one_in,
    output logic                   test_strap_one_out,
    output logic                   test_strap_one_oe,
    input  wire logic              test_strap_two_in,
    output logic                   test_strap_two_out,
    output logic                   test_strap_two_oe,
    input  wire logic              test_strap_three_in,
    output logic                   test_strap_three_out,
    output logic                   test_strap_three_oe,
    input  wire logic              test_strap_four_in,
    output logic                   test_strap_four_out,
    output logic                   test_strap_four_oe,
    input  wire logic              spread_disable_strap_in,
    output logic                   spread_disable_strap_out,
    output logic                   spread_disable_strap_oe,
    output logic [strap_pkg::STRAP_COUNT-1:0] strap_pulldown_en,
    output logic                   reserved_enable_pin_out,
    output logic                   reserved_enable_pin_oe,
    output logic                   trace_clock_out,
    output logic                   trace_control_out,
    // Configuration results
    input  wire logic              diag_check_nvm,
    output logic                   host_use_checksum,
    output logic                   diag_use_checksum,
    output logic                   stay_in_boot,
    output logic                   spread_enable,
    output logic                   straps_valid,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import strap_pkg::*;

    logic [STRAP_COUNT-1:0] pin_in;
    logic [STRAP_COUNT-1:0] pin_out;
    logic [STRAP_COUNT-1:0] pin_oe;
    logic [STRAP_COUNT-1:0] strap_value_reg;
    logic [STRAP_COUNT-1:0] pulldown_reg;
    logic                   diag_reg;
    logic                   capture_pulse;
    capture_state_t         cap_state;
    logic                   captured;
    logic [31:0]            debug_reg;
    logic [ADDR_W-1:0]      aw_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   aw_got_reg;
    logic                   w_got_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   rvalid_reg;
    logic [31:0]            rdata_reg;
    logic [1:0]             rresp_reg;
    logic                   do_write;
    logic                   write_hit;
    logic [31:0]            status_word;

    ////////////////////////////////////////////////////////////////////////
    // Pad gathering; index order follows the package positions
    assign pin_in = {spread_disable_strap_in, test_strap_four_in, test_strap_three_in,
                     test_strap_two_in, test_strap_one_in, boot_hold_strap_in,
                     integrity_select_strap_in};
    assign {spread_disable_strap_out, test_strap_four_out, test_strap_three_out,
            test_strap_two_out, test_strap_one_out, boot_hold_strap_out,
            integrity_select_strap_out} = pin_out;
    assign {spread_disable_strap_oe, test_strap_four_oe, test_strap_three_oe,
            test_strap_two_oe, test_strap_one_oe, boot_hold_strap_oe,
            integrity_select_strap_oe} = pin_oe;

    strap_capture_timer #(
        .DELAY_CYCLES (DELAY_CYCLES)
    ) u_timer (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .por_n_input   (por_n_input),
        .capture_pulse (capture_pulse),
        .state         (cap_state)
    );

    assign captured = (cap_state == ST_CAPTURED);

    ////////////////////////////////////////////////////////////////////////
    // Debug drive per pin: only after capture, and gated by the power-on
    // input directly so the pads float in the very cycle it falls
    genvar gi;
    generate
        for (gi = 0; gi < STRAP_COUNT; gi++) begin : g_pad
            assign pin_oe[gi]  = por_n_input && captured
                                 && debug_reg[DBG_OE_LSB + gi];
            assign pin_out[gi] = debug_reg[DBG_OUT_LSB + gi];
        end
    endgenerate

    // Reserved pad is never driven; it exists only to keep it floating
    assign reserved_enable_pin_out = 1'b0;
    assign reserved_enable_pin_oe  = 1'b0;
    assign strap_pulldown_en       = pulldown_reg;

    // Weak pull-downs stay on, except from one cycle after a pin's debug drive is enabled until one cycle after it ends, so an open strap resolves to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulldown_reg <= PULLDOWN_RESET;
        end else begin
            pulldown_reg <= por_n_input ? ~pin_oe : PULLDOWN_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Captured straps: taken once, then frozen until the next assertion
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n_input) begin
            strap_value_reg <= STRAP_RESET;
        end else if (capture_pulse) begin
            strap_value_reg <= pin_in;
        end
    end

    // Diagnostic check method tracks the stored setting, not the strap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_reg <= 1'b0;
        end else begin
            diag_reg <= diag_check_nvm;
        end
    end

    assign host_use_checksum = strap_value_reg[STRAP_INTEGRITY];
    assign stay_in_boot      = strap_value_reg[STRAP_BOOT_HOLD];
    assign spread_enable     = strap_value_reg[STRAP_SPREAD];
    assign diag_use_checksum = diag_reg;
    assign straps_valid      = captured;
    assign trace_clock_out   = captured && debug_reg[DBG_TRACE_CLK_BIT];
    assign trace_control_out = captured && debug_reg[DBG_TRACE_CTL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order, applied
    // one cycle after both are held; one write outstanding at a time
    assign s_axi_awready = !aw_got_reg;
    assign s_axi_wready  = !w_got_reg;
    assign do_write      = aw_got_reg && w_got_reg && !bvalid_reg;
    assign write_hit     = (aw_addr_reg[7:0] == DEBUG_OFFSET) || (aw_addr_reg[7:0] == STATUS_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg  <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && !aw_got_reg) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_got_reg  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_reg  <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && !w_got_reg) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_got_reg  <= 1'b0;
        end
    end

    // Debug control; status is read-only so writes there are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_reg <= DEBUG_RESET;
        end else if (do_write && aw_addr_reg[7:0] == DEBUG_OFFSET) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_reg[b]) begin
                    debug_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8] & DEBUG_MASK[b*8 +: 8];
                end
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= write_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read: answer registered one cycle after the address
    always_comb begin
        status_word = '0;
        status_word[STAT_CAPTURED_BIT] = captured;
        status_word[STAT_POR_BIT]      = por_n_input;
        status_word[STAT_DIAG_BIT]     = diag_reg;
        status_word[STAT_STRAP_LSB +: STRAP_COUNT] = strap_value_reg;
    end

    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            unique case (s_axi_araddr[7:0])
                STATUS_OFFSET: begin
                    rdata_reg <= status_word;
                    rresp_reg <= RESP_OKAY;
                end
                DEBUG_OFFSET: begin
                    rdata_reg <= debug_reg;
                    rresp_reg <= RESP_OKAY;
                end
                default: begin
                    rdata_reg <= '0;
                    rresp_reg <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    por_clears_all_a: assert property (!por_n_input |=> !captured && strap_value_reg == '0)
        else $error("power-on assertion did not clear the captured straps");

    integrity_map_a: assert property (capture_pulse |=> host_use_checksum == $past(integrity_select_strap_in))
        else $error("host check method does not follow the integrity strap");

    diag_source_a: assert property (1'b1 |=> diag_use_checksum == $past(diag_check_nvm))
        else $error("diagnostic check method does not follow the stored setting");

    pins_released_a: assert property (!por_n_input |-> pin_oe == '0 && !reserved_enable_pin_oe)
        else $error("strap pin driven while power-on input is low");

    capture_delay_a: assert property (capture_pulse |-> por_n_input && $past(por_n_input, DELAY_CYCLES) && !$past(por_n_input, DELAY_CYCLES+1))
        else $error("straps captured at the wrong time after release");

    debug_after_a: assert property (|pin_oe |-> captured && !capture_pulse)
        else $error("strap pin driven before its value was captured");

    boot_map_a: assert property (capture_pulse |=> stay_in_boot == $past(boot_hold_strap_in))
        else $error("boot path does not follow the boot-hold strap");

    spread_map_a: assert property (capture_pulse |=> spread_enable == $past(spread_disable_strap_in))
        else $error("spread clocking does not follow the spread strap");

    pulldown_on_a: assert property (!por_n_input |=> strap_pulldown_en == PULLDOWN_RESET)
        else $error("pull-downs not applied while pins are released");

    value_hold_a: assert property (captured && por_n_input |=> $stable(strap_value_reg))
        else $error("captured strap value changed before reassertion");

    capture_seen_c: cover property (capture_pulse ##1 captured);
    debug_drive_c: cover property (captured ##[1:20] |pin_oe);
    write_done_c: cover property (do_write ##1 s_axi_bvalid);
    reassert_c: cover property (captured ##1 !por_n_input);

endmodule

// [strap_pkg.sv]
/*
 * Constants shared by the strap capture block: pin indices, timing,
 * register offsets and field positions.
 * Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
// Function
// - Active-low power-on input holds logic in reset
// - Integrity strap: 0 selects CRC, 1 checksum
// - Diagnostic port check comes from stored setting
// - Strap pins undriven while power-on input low
// - Straps captured 1.5 us after power-on release
// - Captured pins may then drive debug outputs
// - Boot strap: 0 loads main, 1 stays boot
// - Spread strap: 0 disables, 1 uses stored settings
// - Weak pull-down makes open straps read zero
package strap_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Strap pin positions inside the captured vector
    localparam int STRAP_COUNT     = 7;
    localparam int STRAP_INTEGRITY = 0;
    localparam int STRAP_BOOT_HOLD = 1;
    localparam int STRAP_TEST_ONE  = 2;
    localparam int STRAP_TEST_FOUR = 5;
    localparam int STRAP_SPREAD    = 6;

    ////////////////////////////////////////////////////////////////////////
    // Timing: sampling delay after the power-on input goes high
    localparam real CLK_PERIOD_NS     = 10.0;
    localparam real CAPTURE_DELAY_US  = 1.5;
    localparam int  CAPTURE_CYCLES    = int'(CAPTURE_DELAY_US * 1000.0 / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] DEBUG_OFFSET  = 8'h04;

    // Status fields
    localparam int STAT_CAPTURED_BIT = 0;
    localparam int STAT_POR_BIT      = 1;
    localparam int STAT_DIAG_BIT     = 2;
    localparam int STAT_STRAP_LSB    = 8;

    // Debug control fields
    localparam int DBG_OUT_LSB       = 0;
    localparam int DBG_OE_LSB        = 8;
    localparam int DBG_TRACE_CLK_BIT = 16;
    localparam int DBG_TRACE_CTL_BIT = 17;
    localparam logic [31:0] DEBUG_MASK  = 32'h0003_7f7f;
    localparam logic [31:0] DEBUG_RESET = 32'h0000_0000;

    // Reset values of the captured straps and pad pull-downs
    localparam logic [STRAP_COUNT-1:0] STRAP_RESET    = 7'h00;
    localparam logic [STRAP_COUNT-1:0] PULLDOWN_RESET = 7'h7f;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Capture sequence states
    typedef enum logic [1:0] {
        ST_HELD     = 2'b00,
        ST_WAITING  = 2'b01,
        ST_CAPTURED = 2'b10
    } capture_state_t;

endpackage

// [strap_capture_timer.sv]
/*
 * Counts the settling delay after the power-on input rises and gives
 * a one-cycle capture pulse, once per release.
 * Assumes por_n_input is already synchronous to aclk.
 */
`timescale 1ns/10ps
module strap_capture_timer #(
    parameter int DELAY_CYCLES = strap_pkg::CAPTURE_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic por_n_input,
    output logic      capture_pulse,
    output strap_pkg::capture_state_t state
);
    import strap_pkg::*;

    localparam int CNT_W = $clog2(DELAY_CYCLES + 1);

    logic [CNT_W-1:0] count_reg;
    capture_state_t   state_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pulse after DELAY_CYCLES edges with the power-on input high; pins taken next edge
    assign capture_pulse = (state_reg == ST_WAITING) && por_n_input
                           && (count_reg == CNT_W'(DELAY_CYCLES - 1));
    assign state         = state_reg;

    // Counter restarts on every assertion, so a short glitch cannot
    // carry a partial count into the next release
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n_input) begin
            count_reg <= '0;
        end else if (state_reg == ST_WAITING) begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    // Sequence state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_HELD;
        end else if (!por_n_input) begin
            state_reg <= ST_HELD;
        end else begin
            unique case (state_reg)
                ST_HELD:     state_reg <= ST_WAITING;
                ST_WAITING:  state_reg <= capture_pulse ? ST_CAPTURED : ST_WAITING;
                ST_CAPTURED: state_reg <= ST_CAPTURED;
                default:     state_reg <= ST_HELD;
            endcase
        end
    end

endmodule

// [board_straps.sv]
/*
 * Board model: pull resistors fitted on the strap pads.
 * Assumes the device gives out/oe pairs and its weak pull-down enables.
 */
`timescale 1ns/10ps
module board_straps (
    input  wire logic       aclk,
    input  wire logic [6:0] pad_out,
    input  wire logic [6:0] pad_oe,
    input  wire logic [6:0] pulldown_en,
    input  wire logic [6:0] pullup_fit,
    output logic      [6:0] pad_level
);
    ////////////////////////////////////////////////////////////////////////
    // Pull-ups are only fitted on selectable straps; test straps stay low
    localparam logic [6:0] PULLUP_OK = 7'h43;
    logic [6:0] last_level;

    // A floating pad shows the inverse of its last level, never a stale one
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pad_oe[i])
                pad_level[i] = pad_out[i];
            else if (pullup_fit[i] & PULLUP_OK[i])
                pad_level[i] = 1'b1;
            else if (pulldown_en[i])
                pad_level[i] = 1'b0;
            else
                pad_level[i] = ~last_level[i];
        end
    end

    // Level memory for the floating case
    always_ff @(posedge aclk) begin
        last_level <= pad_level;
    end
    // Reserved enable and trace outputs are left unconnected here
endmodule

// [reset_strap_sampler_tb_top.sv]
/*
 * Testbench for the strap sampler: drives power-on and AXI4-Lite.
 * Assumes board_straps for the pads and a short capture delay.
 */
`timescale 1ns/10ps
module reset_strap_sampler_tb_top;
    import strap_pkg::*;
    localparam int DLY = 4;
    logic        aclk, aresetn, por, diag, host_ck, diag_ck, boot, spread, valid, tclk, tctl;
    logic [6:0]  pout, poe, pdn, pup, pad;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, r, res;
    int          fails, tests_run, n;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and board
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    reset_strap_sampler #(.DELAY_CYCLES(DLY)) dut (
        .aclk(aclk), .aresetn(aresetn), .por_n_input(por),
        .integrity_select_strap_in(pad[0]), .integrity_select_strap_out(pout[0]),
        .integrity_select_strap_oe(poe[0]), .boot_hold_strap_in(pad[1]),
        .boot_hold_strap_out(pout[1]), .boot_hold_strap_oe(poe[1]),
        .test_strap_one_in(pad[2]), .test_strap_one_out(pout[2]), .test_strap_one_oe(poe[2]),
        .test_strap_two_in(pad[3]), .test_strap_two_out(pout[3]), .test_strap_two_oe(poe[3]),
        .test_strap_three_in(pad[4]), .test_strap_three_out(pout[4]),
        .test_strap_three_oe(poe[4]), .test_strap_four_in(pad[5]),
        .test_strap_four_out(pout[5]), .test_strap_four_oe(poe[5]),
        .spread_disable_strap_in(pad[6]), .spread_disable_strap_out(pout[6]),
        .spread_disable_strap_oe(poe[6]), .strap_pulldown_en(pdn),
        .reserved_enable_pin_out(res[0]), .reserved_enable_pin_oe(res[1]),
        .trace_clock_out(tclk), .trace_control_out(tctl), .diag_check_nvm(diag),
        .host_use_checksum(host_ck), .diag_use_checksum(diag_ck), .stay_in_boot(boot),
        .spread_enable(spread), .straps_valid(valid),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    board_straps board (
        .aclk(aclk), .pad_out(pout), .pad_oe(poe), .pulldown_en(pdn),
        .pullup_fit(pup), .pad_level(pad)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare, closing and bus tasks
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A bound that runs out is a mismatch and ends the run
    task automatic timed_out(input int k);
        if (k >= 64) begin
            fails++;
            $display("[FAIL] handshake expected answer seen timeout");
            close_out();
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
        bit aw, w;
        int k;
        // One edge between calls so no signal is assigned twice in a step
        @(posedge aclk);
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (aw && w && bvalid)
                break;
            if (awready && !aw)
                awvalid <= 1'b0;
            if (wready && !w)
                wvalid <= 1'b0;
            aw = aw | awready;
            w = w | wready;
        end
        timed_out(k);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
        bit got;
        int k;
        @(posedge aclk);
        got = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (got && rvalid)
                break;
            if (arready && !got) begin
                got = 1;
                arvalid <= 1'b0;
            end
        end
        timed_out(k);
        v = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    // Edges from power-on release until straps_valid is sampled high
    task automatic wait_valid(output int cnt);
        for (cnt = 1; cnt < 64; cnt++) begin
            @(posedge aclk);
            if (valid === 1'b1)
                break;
        end
        timed_out(cnt);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {aresetn, por, diag, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {awaddr, araddr, wdata, pup, fails, tests_run} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (30) @(posedge aclk);
        check("pad_oe", 32'h0, poe);
        check("pulldown", 32'h7f, pdn);
        check("valid", 32'h0, valid);
        axi_rd(STATUS_OFFSET, d, r);
        check("status", 32'h0, d);
        axi_rd(DEBUG_OFFSET, d, r);
        check("debug", DEBUG_RESET, d);
        $display("Test held done");
        // Pull-ups on every pad; the board keeps test straps low
        pup <= 7'h7f;
        diag <= 1'b1;
        por <= 1'b1;
        wait_valid(n);
        check("delay", DLY + 2, n);
        check("results", 32'h1f, {host_ck, diag_ck, boot, spread, valid});
        axi_rd(STATUS_OFFSET, d, r);
        check("status", 32'h4307, d);
        $display("Test capture done");
        // Debug drive must not disturb captured values
        axi_wr(DEBUG_OFFSET, 32'hffff_ff55, r);
        check("bresp", RESP_OKAY, r);
        axi_rd(DEBUG_OFFSET, d, r);
        check("debug", 32'h0003_7f55, d);
        check("drive", 32'h7f55_0003, {1'b0, poe, 1'b0, pad, 14'h0, tclk, tctl});
        check("pulldown", 32'h0, pdn);
        axi_wr(STATUS_OFFSET, 32'h0, r);
        check("bresp", RESP_OKAY, r);
        axi_rd(STATUS_OFFSET, d, r);
        check("status", 32'h4307, d);
        check("results", 32'h1f, {host_ck, diag_ck, boot, spread, valid});
        axi_wr(8'h08, 32'h1, r);
        check("bresp", RESP_DECERR, r);
        axi_rd(8'h08, d, r);
        check("rdata", 32'h0, {d[29:0], r ^ RESP_DECERR});
        $display("Test debug done");
        // Power-on reset again: pads released, then an aborted release
        por <= 1'b0;
        pup <= 7'h00;
        @(posedge aclk);
        check("pad_oe", 32'h0, {poe, res});
        @(posedge aclk);
        check("valid", 32'h0, {valid, tclk, tctl});
        por <= 1'b1;
        repeat (DLY - 2) @(posedge aclk);
        por <= 1'b0;
        repeat (DLY + 4) @(posedge aclk);
        check("valid", 32'h0, valid);
        por <= 1'b1;
        wait_valid(n);
        check("results", 32'h09, {host_ck, diag_ck, boot, spread, valid});
        $display("Test reassert done");
        close_out();
    end
endmodule
